// ### bank_share_flags.sv
// request flag pair of one storage bank
module bank_share_flags (
	input  logic clock,       // 100 mhz clock
	input  logic rstn,        // sync reset, active low
	input  logic ctl_wr,      // controller writes share control
	input  logic ctl_bit,     // written controller request bit
	input  logic unaware_wr1, // write carries host unaware = 1
	input  logic unaware_nxt, // host unaware after this cycle
	input  logic host_set,    // host asks for the bank
	input  logic host_clr,    // host releases the bank
	output logic ctrl_req,    // controller request flag
	output logic host_req     // host request flag
);
	import cmos_share_pkg::*;

	typedef struct packed {
		logic ctrl;
		logic host;
	} flag_state_type;

	flag_state_type s_r;
	flag_state_type s_nxt;
	logic           ctrl_try;

	// next flag values
	always_comb begin
		s_nxt    = s_r;
		ctrl_try = ctl_wr & ctl_bit;
		if (ctl_wr) begin
			// refused unless host flag clear and sharing in force
			s_nxt.ctrl = ctl_bit & ~s_r.host & ~unaware_nxt;
		end
		if (unaware_wr1) begin
			s_nxt.host = 1'b0;
		end else if (host_clr) begin
			s_nxt.host = 1'b0;
		end else if (host_set & ~s_r.ctrl & ~ctrl_try & ~unaware_nxt) begin
			s_nxt.host = 1'b1;
		end
	end

	// flag register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ctrl_req = s_r.ctrl;
	assign host_req = s_r.host;
endmodule

// ### cmos_ram_share_arbiter.sv
// cmos storage sharing arbiter between host and embedded controller

module cmos_ram_share_arbiter (
	input  logic                         clock,                 // 100 mhz clock
	input  logic                         rstn,                  // sync reset, active low
	input  cmos_share_pkg::reg_req_type  reg_req,               // controller register access
	output logic [7:0]                   rdata,                 // read data, registered
	output logic                         rd_valid,              // read data valid pulse
	input  cmos_share_pkg::host_req_type host_req,              // host request strobes
	input  logic                         host_reset_active,     // host reset output asserted
	input  logic                         main_host_power_plane, // host power plane on
	output cmos_share_pkg::grant_type    grant,                 // bank ownership
	output logic [7:0]                   share_status,          // share control image
	output cmos_share_pkg::cmos_bus_type store_bus,             // storage bus, registered
	input  logic [7:0]                   cmos_rdata             // storage read data
);
	import cmos_share_pkg::*;

	typedef struct packed {
		logic         unaware;
		logic [7:0]   idx_low;
		logic [7:0]   idx_high;
		logic         rd_pend;
		logic         rd_storage;
		logic [7:0]   rd_hold;
		logic [7:0]   rdata;
		logic         rd_valid;
		cmos_bus_type bus;
	} arb_state_type;

	localparam arb_state_type ARB_RESET = '{
		unaware:    RST_HOST_UNAWARE,
		idx_low:    RST_INDEX,
		idx_high:   RST_INDEX,
		rd_pend:    1'b0,
		rd_storage: 1'b0,
		rd_hold:    RST_DATA,
		rdata:      RST_DATA,
		rd_valid:   1'b0,
		bus:        '0
	};

	arb_state_type s_r;
	arb_state_type s_nxt;
	reg_sel_type   sel;
	logic          forced;
	logic          ctl_wr;
	logic          unaware_wr1;
	logic          unaware_nxt;
	logic [1:0]    ctrl_req;
	logic [1:0]    host_flag;
	logic [1:0]    ctrl_own;
	logic [1:0]    host_own;
	logic [7:0]    ctl_value;
	logic [7:0]    idx_sel;
	logic          bank_sel;
	logic          own_sel;
	logic          mirror_hit;

	share_reg_decode share_reg_decode_i (
		.addr (reg_req.addr),
		.sel  (sel)
	);

	// share control write terms
	assign ctl_wr      = reg_req.wr & sel.ctl;
	assign unaware_wr1 = ctl_wr & reg_req.wdata[BIT_HOST_UNAWARE];
	assign unaware_nxt = ctl_wr ? reg_req.wdata[BIT_HOST_UNAWARE] : s_r.unaware;

	// one flag pair per bank
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			bank_share_flags bank_share_flags_i (
				.clock       (clock),
				.rstn        (rstn),
				.ctl_wr      (ctl_wr),
				.ctl_bit     (reg_req.wdata[b ? BIT_CTRL_REQ_HIGH : BIT_CTRL_REQ_LOW]),
				.unaware_wr1 (unaware_wr1),
				.unaware_nxt (unaware_nxt),
				.host_set    (host_req.set[b]),
				.host_clr    (host_req.clr[b]),
				.ctrl_req    (ctrl_req[b]),
				.host_req    (host_flag[b])
			);
			// host reset or host power off hands storage to the controller
			assign ctrl_own[b] = forced | (~s_r.unaware & ctrl_req[b]);
			assign host_own[b] = ~forced & (s_r.unaware | host_flag[b]);
		end
	endgenerate

	assign forced = host_reset_active | ~main_host_power_plane;

	// share control image, refused requests read as zero
	always_comb begin
		ctl_value                    = '0;
		ctl_value[BIT_HOST_UNAWARE]  = s_r.unaware;
		ctl_value[BIT_CTRL_REQ_HIGH] = ctrl_req[1];
		ctl_value[BIT_HOST_REQ_HIGH] = host_flag[1];
		ctl_value[BIT_CTRL_REQ_LOW]  = ctrl_req[0];
		ctl_value[BIT_HOST_REQ_LOW]  = host_flag[0];
	end

	// bank and location picked by a data access
	assign bank_sel   = sel.dat[1];
	assign idx_sel    = bank_sel ? s_r.idx_high : s_r.idx_low;
	assign own_sel    = ctrl_own[bank_sel];
	assign mirror_hit = ~bank_sel & (idx_sel[BANK_AW-1:0] == MIRROR_SLOT);

	// next state: register writes, storage strobes, read pipeline
	always_comb begin
		s_nxt          = s_r;
		s_nxt.bus.we   = 1'b0;
		s_nxt.bus.re   = 1'b0;
		s_nxt.rd_pend  = 1'b0;
		s_nxt.rd_valid = s_r.rd_pend;
		if (ctl_wr) begin
			s_nxt.unaware = reg_req.wdata[BIT_HOST_UNAWARE];
		end
		if (reg_req.wr & sel.idx[0]) begin
			s_nxt.idx_low = reg_req.wdata;
		end
		if (reg_req.wr & sel.idx[1]) begin
			s_nxt.idx_high = reg_req.wdata;
		end
		// storage write only when owned and not the mirror slot
		if (reg_req.wr & (|sel.dat) & own_sel & ~mirror_hit) begin
			s_nxt.bus.we    = 1'b1;
			s_nxt.bus.addr  = {bank_sel, idx_sel[BANK_AW-1:0]};
			s_nxt.bus.wdata = reg_req.wdata;
		end
		if (reg_req.rd) begin
			s_nxt.rd_pend    = 1'b1;
			s_nxt.rd_storage = 1'b0;
			s_nxt.rd_hold    = '0;
			if (sel.ctl) begin
				s_nxt.rd_hold = ctl_value;
			end else if (sel.idx[0]) begin
				s_nxt.rd_hold = s_r.idx_low;
			end else if (sel.idx[1]) begin
				s_nxt.rd_hold = s_r.idx_high;
			end else if ((|sel.dat) & own_sel & mirror_hit) begin
				s_nxt.rd_hold = ctl_value;
			end else if ((|sel.dat) & own_sel) begin
				s_nxt.rd_storage = 1'b1;
				s_nxt.bus.re     = 1'b1;
				s_nxt.bus.addr   = {bank_sel, idx_sel[BANK_AW-1:0]};
			end
		end
		// second read stage takes storage or held value
		if (s_r.rd_pend) begin
			s_nxt.rdata = s_r.rd_storage ? cmos_rdata : s_r.rd_hold;
		end
	end

	// state register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			s_r <= ARB_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata        = s_r.rdata;
	assign rd_valid     = s_r.rd_valid;
	assign store_bus    = s_r.bus;
	assign grant.ctrl   = ctrl_own;
	assign grant.host   = host_own;
	assign share_status = ctl_value;

	// checks
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	logic low_wr_own;
	assign low_wr_own = reg_req.wr & sel.dat[0] & ctrl_own[0] & ~mirror_hit;

	a_unaware_clears_host: assert property (
		unaware_wr1 |=> (host_flag == 2'b00) && s_r.unaware)
		else $error("host requests survived host unaware write");

	a_unaware_grants_host: assert property (
		(s_r.unaware && !forced) |-> (host_own == 2'b11) && (ctrl_own == 2'b00))
		else $error("host not granted while host unaware");

	a_forced_ctrl_owns: assert property (
		forced |-> (ctrl_own == 2'b11) && (host_own == 2'b00))
		else $error("controller lacks storage while host is down");

	a_ctrl_low_refused: assert property (
		(ctl_wr && reg_req.wdata[BIT_CTRL_REQ_LOW] && host_flag[0])
		|=> !ctrl_req[0] && !ctl_value[BIT_CTRL_REQ_LOW])
		else $error("controller low request set over host request");

	a_ctrl_high_refused: assert property (
		(ctl_wr && reg_req.wdata[BIT_CTRL_REQ_HIGH] && host_flag[1]) |=> !ctrl_req[1])
		else $error("controller high request set over host request");

	a_host_low_refused: assert property (
		(host_req.set[0] && ctrl_req[0] && !host_req.clr[0]) |=> !host_flag[0])
		else $error("host low request set over controller request");

	a_host_high_refused: assert property (
		(host_req.set[1] && ctrl_req[1] && !host_req.clr[1]) |=> !host_flag[1])
		else $error("host high request set over controller request");

	a_tie_ctrl_wins: assert property (
		(ctl_wr && reg_req.wdata[BIT_CTRL_REQ_HIGH] && host_req.set[1] && !host_flag[1]
		 && !reg_req.wdata[BIT_HOST_UNAWARE] && !forced) |=> ctrl_own[1] && !host_flag[1])
		else $error("same cycle request not given to controller");

	a_low_write_path: assert property (
		low_wr_own |=> store_bus.we && store_bus.addr == {1'b0, $past(s_r.idx_low[6:0])}
		&& store_bus.wdata == $past(reg_req.wdata))
		else $error("owned low write not sent to indexed location");

	a_no_own_no_write: assert property (
		(reg_req.wr && (|sel.dat) && !own_sel && !reg_req.rd) |=> !store_bus.we)
		else $error("storage written without ownership");

	a_mirror_no_write: assert property (
		(reg_req.wr && sel.dat[0] && mirror_hit) |=> !store_bus.we)
		else $error("mirror slot written as storage");

	a_unowned_reads_zero: assert property (
		(reg_req.rd && (|sel.dat) && !own_sel) |=> !store_bus.re ##1 rd_valid && rdata == 8'h00)
		else $error("unowned data read not zero");

	// reset values, read and write path timing and data
	a_reset_values: assert property (
		!$past(rstn) |-> s_r.unaware && ctrl_req == 2'b00 && host_flag == 2'b00 && !rd_valid)
		else $error("state not at reset values after reset");

	a_rd_valid_timing: assert property (
		reg_req.rd |-> ##2 rd_valid)
		else $error("read result not valid two cycles after request");

	a_rd_valid_pulse: assert property (
		(rd_valid && !$past(reg_req.rd)) |=> !rd_valid)
		else $error("read valid held longer than one cycle");

	a_valid_needs_read: assert property (
		!reg_req.rd |-> ##2 !rd_valid)
		else $error("read valid without a read request");

	a_we_needs_sel: assert property (
		store_bus.we |-> $past(reg_req.wr) && $past(|sel.dat) && $past(own_sel))
		else $error("storage write without an owned data write");

	a_re_needs_own: assert property (
		store_bus.re |-> $past(reg_req.rd) && $past(|sel.dat) && $past(own_sel))
		else $error("storage read without an owned data read");

	a_high_write_path: assert property (
		(reg_req.wr && sel.dat[1] && ctrl_own[1])
		|=> store_bus.we && store_bus.addr == {1'b1, $past(s_r.idx_high[6:0])})
		else $error("owned high write not sent to indexed location");

	a_owned_read_path: assert property (
		(reg_req.rd && (|sel.dat) && own_sel && !mirror_hit)
		|=> store_bus.re && store_bus.addr == {$past(bank_sel), $past(idx_sel[6:0])})
		else $error("owned read not sent to indexed location");

	a_owned_read_data: assert property (
		(reg_req.rd && (|sel.dat) && own_sel && !mirror_hit)
		|-> ##2 rd_valid && rdata == $past(cmos_rdata))
		else $error("storage read data not returned");

	a_mirror_read: assert property (
		(reg_req.rd && sel.dat[0] && own_sel && mirror_hit) |-> ##2 rdata == $past(ctl_value, 2))
		else $error("mirror slot read not share control image");

	a_low_bank_range: assert property (
		(reg_req.wr && sel.dat[0] && ctrl_own[0] && !mirror_hit) |=> !store_bus.addr[7])
		else $error("low bank write left the low half");

	a_ctl_read: assert property (
		(reg_req.rd && sel.ctl) |-> ##2 rdata == $past(ctl_value, 2))
		else $error("share control read not its image");

	a_index_read: assert property (
		(reg_req.rd && sel.idx[0]) |-> ##2 rdata == $past(s_r.idx_low, 2))
		else $error("low index read not the full stored byte");

	a_unmapped_read: assert property (
		(reg_req.rd && !sel.ctl && sel.idx == 2'b00 && sel.dat == 2'b00) |-> ##2 rdata == 8'h00)
		else $error("unmapped read not zero");

	// request flags and ownership
	a_ctrl_set_accept: assert property (
		(ctl_wr && reg_req.wdata[BIT_CTRL_REQ_LOW] && !host_flag[0]
		 && !reg_req.wdata[BIT_HOST_UNAWARE]) |=> ctrl_req[0])
		else $error("free low bank not granted to controller");

	a_ctrl_release: assert property (
		(ctl_wr && !reg_req.wdata[BIT_CTRL_REQ_HIGH]) |=> !ctrl_req[1])
		else $error("controller high request not released");

	a_host_set_accept: assert property (
		(host_req.set[0] && !host_req.clr[0] && !ctrl_req[0] && !ctl_wr && !s_r.unaware)
		|=> host_flag[0])
		else $error("free low bank not granted to host");

	a_host_clear: assert property (
		host_req.clr[0] |=> !host_flag[0])
		else $error("host low request not released");

	a_single_owner: assert property (
		(ctrl_own & host_own) == 2'b00)
		else $error("bank owned by both sides");

	a_flags_exclusive: assert property (
		!(ctrl_req[0] && host_flag[0]) && !(ctrl_req[1] && host_flag[1]))
		else $error("both request flags of a bank set");

	a_no_owner_idle: assert property (
		(!forced && !s_r.unaware && !ctrl_req[0] && !host_flag[0])
		|-> !ctrl_own[0] && !host_own[0])
		else $error("idle low bank has an owner");

	a_unaware_blocks_ctrl: assert property (
		(ctl_wr && reg_req.wdata[BIT_HOST_UNAWARE]) |=> ctrl_req == 2'b00)
		else $error("controller request taken while host unaware");

	c_ctrl_takes_low: cover property (ctl_wr && reg_req.wdata[BIT_CTRL_REQ_LOW] ##1 ctrl_own[0]);
	c_host_takes_high: cover property (host_req.set[1] ##1 host_own[1] && !s_r.unaware);
	c_storage_read: cover property (store_bus.re ##1 rd_valid);
	c_tie: cover property (ctl_wr && host_req.set[1] && reg_req.wdata[BIT_CTRL_REQ_HIGH]);
endmodule

// ### cmos_ram_share_arbiter_tb_top.sv
// self-checking bench for the cmos storage sharing arbiter
module cmos_ram_share_arbiter_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import cmos_share_pkg::*;
	logic         clock;
	logic         rstn;
	reg_req_type  reg_req;
	logic [7:0]   rdata;
	logic         rd_valid;
	host_req_type host_req;
	logic         host_reset_active;
	logic         main_host_power_plane;
	grant_type    grant;
	logic [7:0]   share_status;
	cmos_bus_type store_bus;
	logic [7:0]   cmos_rdata;
	logic         re_seen;
	logic [7:0]   d;
	int           miscompares;
	int           checked;

	cmos_ram_share_arbiter cmos_ram_share_arbiter_i (
		.clock(clock), .rstn(rstn), .reg_req(reg_req), .rdata(rdata), .rd_valid(rd_valid),
		.host_req(host_req), .host_reset_active(host_reset_active),
		.main_host_power_plane(main_host_power_plane), .grant(grant),
		.share_status(share_status), .store_bus(store_bus), .cmos_rdata(cmos_rdata)
	);
	cmos_store_model cmos_store_model_i (
		.clock(clock), .store_bus(store_bus), .cmos_rdata(cmos_rdata)
	);

	// clock generation
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic results();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	// one write pulse; returns in the cycle the storage bus shows it
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] v);
		@(negedge clock);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = v;
		@(negedge clock);
		reg_req.wr = 1'b0;
	endtask

	// one read pulse, bounded wait for rd_valid
	task automatic reg_rd(input logic [15:0] a, output logic [7:0] v);
		int n;
		@(negedge clock);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge clock);
		reg_req.rd = 1'b0;
		re_seen = store_bus.re;
		n = 1;
		while (rd_valid !== 1'b1 && n < 5) begin
			@(negedge clock);
			n++;
		end
		if (rd_valid !== 1'b1) begin
			check("rd_valid", 8'h01, {7'h0, rd_valid});
			results();
		end
		v = rdata;
		check("read latency", 8'(READ_LATENCY), 8'(n));
		@(negedge clock);
		check("rd_valid pulse", 8'h00, {7'h0, rd_valid});
	endtask

	task automatic host_strobe(input logic [1:0] s, input logic [1:0] c);
		@(negedge clock);
		host_req.set = s;
		host_req.clr = c;
		@(negedge clock);
		host_req = '0;
	endtask

	task automatic t_reset();
		check("status", 8'h80, share_status);
		check("host grant", 8'h03, {6'h0, grant.host});
		reg_rd(OFS_SHARE_CONTROL, d);
		check("share ctl", 8'h80, d);
		reg_rd(OFS_INDEX_LOW, d);
		check("index low", 8'h00, d);
		reg_rd(OFS_INDEX_HIGH, d);
		check("index high", 8'h00, d);
	endtask

	task automatic t_unaware();
		reg_wr(OFS_SHARE_CONTROL, 8'h8a);
		check("status", 8'h80, share_status);
		host_strobe(2'b11, 2'b00);
		check("status", 8'h80, share_status);
		check("ctrl grant", 8'h00, {6'h0, grant.ctrl});
	endtask

	task automatic t_low_share();
		reg_wr(OFS_SHARE_CONTROL, 8'h00);
		host_strobe(2'b01, 2'b00);
		check("status", 8'h01, share_status);
		check("host grant", 8'h01, {6'h0, grant.host});
		reg_wr(OFS_SHARE_CONTROL, 8'h02);
		check("status", 8'h01, share_status);
		host_strobe(2'b00, 2'b01);
		check("grants", 8'h00, {4'h0, grant});
		reg_wr(OFS_SHARE_CONTROL, 8'h02);
		check("ctrl grant", 8'h01, {6'h0, grant.ctrl});
		host_strobe(2'b01, 2'b00);
		check("status", 8'h02, share_status);
	endtask

	// controller write and host set of the high bank in one cycle
	task automatic t_tie_high();
		@(negedge clock);
		reg_req.wr = 1'b1;
		reg_req.addr = OFS_SHARE_CONTROL;
		reg_req.wdata = 8'h0a;
		host_req.set = 2'b10;
		@(negedge clock);
		reg_req.wr = 1'b0;
		host_req = '0;
		check("status", 8'h0a, share_status);
		check("ctrl grant", 8'h03, {6'h0, grant.ctrl});
		host_strobe(2'b10, 2'b00);
		check("status", 8'h0a, share_status);
	endtask

	task automatic t_data();
		reg_wr(OFS_INDEX_LOW, 8'h85);
		reg_rd(OFS_INDEX_LOW, d);
		check("index low", 8'h85, d);
		reg_wr(OFS_DATA_LOW, 8'haa);
		check("we", 8'h01, {7'h0, store_bus.we});
		check("addr", 8'h05, store_bus.addr);
		check("wdata", 8'haa, store_bus.wdata);
		reg_wr(OFS_INDEX_HIGH, 8'h03);
		reg_wr(OFS_DATA_HIGH, 8'h55);
		check("addr", 8'h83, store_bus.addr);
		reg_rd(OFS_DATA_LOW, d);
		check("data low", 8'haa, d);
		reg_rd(OFS_DATA_HIGH, d);
		check("data high", 8'h55, d);
	endtask

	task automatic t_mirror();
		reg_wr(OFS_INDEX_LOW, 8'h7f);
		reg_wr(OFS_DATA_LOW, 8'h11);
		check("we", 8'h00, {7'h0, store_bus.we});
		reg_rd(OFS_DATA_LOW, d);
		check("mirror", 8'h0a, d);
	endtask

	task automatic t_not_owned();
		reg_wr(OFS_SHARE_CONTROL, 8'h02);
		host_strobe(2'b10, 2'b00);
		check("status", 8'h06, share_status);
		check("host grant", 8'h02, {6'h0, grant.host});
		reg_wr(OFS_SHARE_CONTROL, 8'h0a);
		check("status", 8'h06, share_status);
		reg_wr(OFS_DATA_HIGH, 8'h77);
		check("we", 8'h00, {7'h0, store_bus.we});
		reg_rd(OFS_DATA_HIGH, d);
		check("data high", 8'h00, d);
		check("re", 8'h00, {7'h0, re_seen});
		reg_wr(OFS_SHARE_CONTROL, 8'h80);
		check("status", 8'h80, share_status);
	endtask

	task automatic t_forced();
		@(negedge clock);
		host_reset_active = 1'b1;
		@(negedge clock);
		check("grants", 8'h0c, {4'h0, grant});
		reg_wr(OFS_INDEX_LOW, 8'h05);
		reg_rd(OFS_DATA_LOW, d);
		check("data low", 8'haa, d);
		host_reset_active = 1'b0;
		main_host_power_plane = 1'b0;
		@(negedge clock);
		check("grants", 8'h0c, {4'h0, grant});
		main_host_power_plane = 1'b1;
		@(negedge clock);
		check("grants", 8'h03, {4'h0, grant});
	endtask

	task automatic t_unmapped();
		reg_wr(16'h7ffa, 8'hff);
		check("status", 8'h80, share_status);
		reg_rd(16'h7ffa, d);
		check("unmapped", 8'h00, d);
	endtask

	// main sequence
	initial begin
		miscompares = 0;
		checked = 0;
		rstn = 1'b0;
		reg_req = '0;
		host_req = '0;
		host_reset_active = 1'b0;
		main_host_power_plane = 1'b1;
		repeat (6) @(negedge clock);
		rstn = 1'b1;
		@(negedge clock);
		t_reset();
		t_unaware();
		t_low_share();
		t_tie_high();
		t_data();
		t_mirror();
		t_not_owned();
		t_forced();
		t_unmapped();
		results();
	end
endmodule

// ### cmos_share_pkg.sv
// constants and carrier types for the cmos storage sharing arbiter
package cmos_share_pkg;
	// register offsets on the controller memory port
	localparam logic [15:0] OFS_SHARE_CONTROL = 16'h7ff5;
	localparam logic [15:0] OFS_INDEX_LOW     = 16'h7ff6;
	localparam logic [15:0] OFS_DATA_LOW      = 16'h7ff7;
	localparam logic [15:0] OFS_INDEX_HIGH    = 16'h7ff8;
	localparam logic [15:0] OFS_DATA_HIGH     = 16'h7ff9;
	// share control field positions
	localparam int BIT_HOST_REQ_LOW  = 0;
	localparam int BIT_CTRL_REQ_LOW  = 1;
	localparam int BIT_HOST_REQ_HIGH = 2;
	localparam int BIT_CTRL_REQ_HIGH = 3;
	localparam int BIT_HOST_UNAWARE  = 7;
	// reset values
	localparam logic       RST_HOST_UNAWARE = 1'b1;
	localparam logic [7:0] RST_SHARE_CONTROL = 8'h80;
	localparam logic [7:0] RST_INDEX = 8'h00;
	localparam logic [7:0] RST_DATA  = 8'h00;
	// storage geometry: two banks of 128, slot 7f of the low bank is the mirror
	localparam int NUM_BANKS = 2;
	localparam int BANK_AW   = 7;
	localparam logic [6:0] MIRROR_SLOT = 7'h7f;
	localparam int READ_LATENCY = 2;

	// controller memory-mapped access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} reg_req_type;

	// host side request strobes, index 0 low bank, 1 high bank
	typedef struct packed {
		logic [1:0] set;
		logic [1:0] clr;
	} host_req_type;

	// bank ownership, index 0 low bank, 1 high bank
	typedef struct packed {
		logic [1:0] ctrl;
		logic [1:0] host;
	} grant_type;

	// storage bus toward the clock and cmos core
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} cmos_bus_type;

	// register selects from the address decode
	typedef struct packed {
		logic       ctl;
		logic [1:0] idx;
		logic [1:0] dat;
	} reg_sel_type;
endpackage

// ### cmos_store_model.sv
// behavioural clock and cmos storage core on the far side of the arbiter
module cmos_store_model (
	input  wire logic                         clock,      // 100 mhz clock
	input  wire cmos_share_pkg::cmos_bus_type store_bus,  // storage bus from the arbiter
	output logic [7:0]                        cmos_rdata  // storage read data
);
	timeunit 1ns;
	timeprecision 1ps;
	import cmos_share_pkg::*;
	logic [7:0] mem [256];
	logic [7:0] last_r;

	// stored on the write pulse, last read kept to spoil idle data
	always @(posedge clock) begin
		if (store_bus.we) begin
			mem[store_bus.addr] <= store_bus.wdata;
		end
		if (store_bus.re) begin
			last_r <= mem[store_bus.addr];
		end
	end

	// read data only while re is high, inverse of last value otherwise
	always_comb begin
		cmos_rdata = store_bus.re ? mem[store_bus.addr] : ~last_r;
	end

	initial begin
		last_r = 8'h00;
	end
endmodule

// ### share_reg_decode.sv
// address decode of the five share registers
module share_reg_decode (
	input  logic [15:0]               addr, // controller address
	output cmos_share_pkg::reg_sel_type sel  // one-hot register select
);
	import cmos_share_pkg::*;

	// plain compare against each offset
	always_comb begin
		sel        = '0;
		sel.ctl    = (addr == OFS_SHARE_CONTROL);
		sel.idx[0] = (addr == OFS_INDEX_LOW);
		sel.dat[0] = (addr == OFS_DATA_LOW);
		sel.idx[1] = (addr == OFS_INDEX_HIGH);
		sel.dat[1] = (addr == OFS_DATA_HIGH);
	end
endmodule
